// *** hw/sgc_pkg.sv ***
// Package of constants for the global switch configuration register bank.
// Assumes an 8-bit register port addressed by 7-bit register index.
package sgc_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_TEST_A     = 7'h09;
    localparam logic [6:0] ADDR_TEST_B     = 7'h0A;
    localparam logic [6:0] ADDR_CPU_CLK    = 7'h0B;
    localparam logic [6:0] ADDR_PRIO_LO    = 7'h0C;
    localparam logic [6:0] ADDR_PRIO_HI    = 7'h0D;
    localparam logic [6:0] ADDR_UNK_FWD    = 7'h0E;
    localparam logic [6:0] ADDR_PHY_BASE   = 7'h0F;
    localparam logic [6:0] ADDR_PORT_FIRST = 7'h10;
    localparam logic [6:0] ADDR_PORT_LAST  = 7'h5F;
    localparam logic [6:0] PORT_STRIDE     = 7'h10;
    localparam int         NUM_PORTS       = 3;
    localparam int         PORT_REGS       = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_TEST_A      = 8'h24;
    localparam logic [7:0] RST_TEST_B      = 8'h35;
    localparam logic [1:0] RST_CPU_CLK_SEL = 2'h2;
    localparam logic [5:0] CPU_CLK_RSVD    = 6'h08;
    localparam logic [7:0] RST_PRIO_LO     = 8'h50;
    localparam logic [7:0] RST_PRIO_HI     = 8'hFA;
    localparam logic       RST_UNK_EN      = 1'b0;
    localparam logic       RST_DRIVE_HI    = 1'b1;
    localparam logic [2:0] RST_UNK_MASK    = 3'h7;
    localparam logic [4:0] RST_PHY_BASE    = 5'h01;
    localparam logic [4:0] PHY_BAD_HI_A    = 5'h1E;
    localparam logic [4:0] PHY_BAD_HI_B    = 5'h1F;
    localparam logic [4:0] PHY_BAD_LO      = 5'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CLK_SEL_LSB   = 6;
    localparam int UNK_EN_BIT    = 7;
    localparam int DRIVE_BIT     = 6;
    localparam int PHY_BASE_LSB  = 3;

    // ----------------------------------------------------------------
    // CPU interface clock choices
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SGC_CLK_31M25 = 2'b00,
        SGC_CLK_62M5  = 2'b01,
        SGC_CLK_125M  = 2'b10,
        SGC_CLK_RSVD  = 2'b11
    } sgc_clk_sel_t;
endpackage

// *** hw/sgc_port_bank.sv ***
// Per-port control register bank: identical layout for every port.
// Assumes the parent decodes port and local index from the address.
module sgc_port_bank (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic       i_wr,
    input  wire logic [1:0] i_port,
    input  wire logic [3:0] i_idx,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    typedef struct packed {
        logic [sgc_pkg::NUM_PORTS*sgc_pkg::PORT_REGS-1:0][7:0] mem;
    } sgc_bank_state_t;

    sgc_bank_state_t st_q;
    sgc_bank_state_t st_d;
    logic [5:0]      slot;

    // Flat index, ports laid out one after another
    assign slot = 6'(i_port) * 6'd16 + 6'(i_idx); // [R11]

    always_comb begin
        st_d = st_q;
        if (i_ce && i_wr && i_port < 2'(sgc_pkg::NUM_PORTS)) begin
            st_d.mem[slot] = i_wdata;
        end
    end

    // Read is combinational; parent registers it
    assign o_rdata = (i_port < 2'(sgc_pkg::NUM_PORTS)) ? st_q.mem[slot] : 8'h00;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// *** hw/sgc_global_regs.sv ***
// Global configuration register bank of a three-port switch.
// Assumes a synchronous register port on i_sys_clk; classifier inputs same clock.
//
// Function
// R1: Clock select 00/01/10 picks 31.25/62.5/125MHz interface clock; reset 10.
// R2: Software should pick 31.25MHz when high serial rate is unneeded.
// R3: Tagged frame priority is the mapping entry indexed by its three-bit tag.
// R4: Tags 0-3 in 0x0C pairs, tags 4-7 in 0x0D; reset 0,0,1,1,2,2,3,3.
// R5: Enable bit 7 sends unknown-destination frames only to masked ports.
// R6: Mask bit2 port3, bit1 port2, bit0 port1; one includes; reset 111.
// R7: PHY base bits 7-3 set port 1 PHY address; 0,30,31 invalid; reset 1.
// R8: Port 2 PHY answers at base address plus one.
// R9: Two factory-test bytes read-only, 0x24 and 0x35.
// R10: Clock register low bits read fixed 00,10,0,0; writes ignore them.
// R11: Per-port control registers share layout, within addresses 16 to 95.
// R12: Port control sets spaced 16 apart: 0x10, 0x20, 0x30.
// R13: Configuration writes affect later frames at once, no reset needed.
module sgc_global_regs (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // Register port
    input  wire logic [6:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Priority lookup
    input  wire logic       i_tag_valid,
    input  wire logic [2:0] i_tag_pcp,
    output logic            o_prio_valid,
    output logic      [1:0] o_prio,
    // Unknown-destination forwarding
    input  wire logic       i_unk_valid,
    input  wire logic [2:0] i_unk_default_ports,
    output logic            o_unk_valid,
    output logic      [2:0] o_unk_ports,
    // PHY management address match
    input  wire logic       i_mgmt_valid,
    input  wire logic [4:0] i_mgmt_phy_addr,
    output logic            o_mgmt_hit_port1,
    output logic            o_mgmt_hit_port2,
    // Static outputs
    output logic      [1:0] o_cpu_clk_sel,
    output logic            o_pad_drive_high,
    output logic            o_phy_base_valid
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clk_sel;
        logic [7:0] prio_lo;
        logic [7:0] prio_hi;
        logic       unk_en;
        logic       drive_hi;
        logic [2:0] unk_mask;
        logic [4:0] phy_base;
        logic [7:0] rdata;
        logic       prio_valid;
        logic [1:0] prio;
        logic       unk_valid;
        logic [2:0] unk_ports;
        logic       hit1;
        logic       hit2;
    } sgc_state_t;

    sgc_state_t st_q;
    sgc_state_t st_d;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_port_addr(input logic [6:0] a);
        return a >= sgc_pkg::ADDR_PORT_FIRST && a <= sgc_pkg::ADDR_PORT_LAST;
    endfunction

    function automatic logic [1:0] prio_entry(input logic [15:0] map, input logic [2:0] tag);
        return map[{tag, 1'b0} +: 2]; // [R3] [R4]
    endfunction

    function automatic logic phy_ok(input logic [4:0] a);
        return a != sgc_pkg::PHY_BAD_LO && a != sgc_pkg::PHY_BAD_HI_A
            && a != sgc_pkg::PHY_BAD_HI_B; // [R7]
    endfunction

    // ----------------------------------------------------------------
    // Per-port bank
    // ----------------------------------------------------------------
    logic [6:0] port_off;
    logic [1:0] port_num;
    logic [7:0] port_rdata;
    logic       port_sel;

    assign port_sel = is_port_addr(i_addr);
    assign port_off = i_addr - sgc_pkg::ADDR_PORT_FIRST;
    assign port_num = port_off[5:4]; // [R12]

    sgc_port_bank u_port_bank (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_wr      (i_wr && port_sel),
        .i_port    (port_num),
        .i_idx     (port_off[3:0]),
        .i_wdata   (i_wdata),
        .o_rdata   (port_rdata)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [15:0] prio_map;
    logic [4:0]  phy_next;

    always_comb begin
        st_d     = st_q;
        prio_map = {st_q.prio_hi, st_q.prio_lo};
        phy_next = st_q.phy_base + 5'h01;

        // Writes; test bytes and reserved bits are not writable
        if (i_wr) begin
            case (i_addr)
                sgc_pkg::ADDR_CPU_CLK: begin
                    st_d.clk_sel = i_wdata[sgc_pkg::CLK_SEL_LSB +: 2]; // [R1] [R10]
                end
                sgc_pkg::ADDR_PRIO_LO: begin
                    st_d.prio_lo = i_wdata; // [R4] [R13]
                end
                sgc_pkg::ADDR_PRIO_HI: begin
                    st_d.prio_hi = i_wdata; // [R4] [R13]
                end
                sgc_pkg::ADDR_UNK_FWD: begin
                    st_d.unk_en   = i_wdata[sgc_pkg::UNK_EN_BIT]; // [R5]
                    st_d.drive_hi = i_wdata[sgc_pkg::DRIVE_BIT];
                    st_d.unk_mask = i_wdata[2:0]; // [R6]
                end
                sgc_pkg::ADDR_PHY_BASE: begin
                    st_d.phy_base = i_wdata[sgc_pkg::PHY_BASE_LSB +: 5]; // [R7]
                end
                default: begin
                end
            endcase
        end

        // Reads: data stand in the next cycle only
        st_d.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                sgc_pkg::ADDR_TEST_A:   st_d.rdata = sgc_pkg::RST_TEST_A; // [R9]
                sgc_pkg::ADDR_TEST_B:   st_d.rdata = sgc_pkg::RST_TEST_B; // [R9]
                sgc_pkg::ADDR_CPU_CLK:  st_d.rdata = {st_q.clk_sel, sgc_pkg::CPU_CLK_RSVD}; // [R10]
                sgc_pkg::ADDR_PRIO_LO:  st_d.rdata = st_q.prio_lo;
                sgc_pkg::ADDR_PRIO_HI:  st_d.rdata = st_q.prio_hi;
                sgc_pkg::ADDR_UNK_FWD:  st_d.rdata = {st_q.unk_en, st_q.drive_hi, 3'h0,
                                                      st_q.unk_mask};
                sgc_pkg::ADDR_PHY_BASE: st_d.rdata = {st_q.phy_base, 3'h0};
                default: begin
                    if (port_sel) begin
                        st_d.rdata = port_rdata; // [R11]
                    end
                end
            endcase
        end

        // Frame classification uses current settings
        st_d.prio_valid = i_tag_valid;
        st_d.prio       = prio_entry(prio_map, i_tag_pcp); // [R3] [R13]

        // Unknown destination: mask only when enabled
        st_d.unk_valid = i_unk_valid;
        st_d.unk_ports = st_q.unk_en ? st_q.unk_mask : i_unk_default_ports; // [R5] [R6]

        // Invalid base codes answer nothing
        st_d.hit1 = i_mgmt_valid && phy_ok(st_q.phy_base)
                    && i_mgmt_phy_addr == st_q.phy_base; // [R7]
        st_d.hit2 = i_mgmt_valid && phy_ok(st_q.phy_base)
                    && i_mgmt_phy_addr == phy_next; // [R8]
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q          <= '0;
            st_q.clk_sel  <= sgc_pkg::RST_CPU_CLK_SEL; // [R1]
            st_q.prio_lo  <= sgc_pkg::RST_PRIO_LO; // [R4]
            st_q.prio_hi  <= sgc_pkg::RST_PRIO_HI; // [R4]
            st_q.unk_en   <= sgc_pkg::RST_UNK_EN; // [R5]
            st_q.drive_hi <= sgc_pkg::RST_DRIVE_HI;
            st_q.unk_mask <= sgc_pkg::RST_UNK_MASK; // [R6]
            st_q.phy_base <= sgc_pkg::RST_PHY_BASE; // [R7]
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata          = st_q.rdata;
    assign o_prio_valid     = st_q.prio_valid;
    assign o_prio           = st_q.prio;
    assign o_unk_valid      = st_q.unk_valid;
    assign o_unk_ports      = st_q.unk_ports;
    assign o_mgmt_hit_port1 = st_q.hit1;
    assign o_mgmt_hit_port2 = st_q.hit2;
    assign o_cpu_clk_sel    = st_q.clk_sel; // [R1]
    assign o_pad_drive_high = st_q.drive_hi;
    assign o_phy_base_valid = phy_ok(st_q.phy_base);
endmodule

// *** sim/sgc_properties.sv ***
// Concurrent checks on the global configuration register bank.
// Assumes it is bound onto sgc_global_regs and sees only its ports.
module sgc_properties (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_ce,
    input wire logic [6:0] i_addr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_tag_valid,
    input wire logic       o_prio_valid,
    input wire logic       i_unk_valid,
    input wire logic       o_unk_valid,
    input wire logic       i_mgmt_valid,
    input wire logic       o_mgmt_hit_port1,
    input wire logic       o_mgmt_hit_port2,
    input wire logic [1:0] o_cpu_clk_sel
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    sequence s_rd(a);
        i_ce && i_rd && i_addr == a;
    endsequence
    property p_test_a;
        s_rd(7'h09) |=> o_rdata == 8'h24;
    endproperty
    a_test_a: assert property (p_test_a) else $error("test byte a wrong");
    property p_test_b;
        s_rd(7'h0A) |=> o_rdata == 8'h35;
    endproperty
    a_test_b: assert property (p_test_b) else $error("test byte b wrong");
    property p_clk_rsvd;
        s_rd(7'h0B) |=> o_rdata[5:0] == 6'h08;
    endproperty
    a_clk_rsvd: assert property (p_clk_rsvd) else $error("clock low bits");
    property p_clk_sel;
        s_rd(7'h0B) |=> o_rdata[7:6] == o_cpu_clk_sel;
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select");
    // ------------------------------------------------------------
    // Lookups answer one cycle later
    // ------------------------------------------------------------
    property p_prio;
        i_ce && i_tag_valid |=> o_prio_valid;
    endproperty
    a_prio: assert property (p_prio) else $error("no priority");
    property p_prio_src;
        o_prio_valid |-> $past(i_tag_valid) || $past(!i_ce);
    endproperty
    a_prio_src: assert property (p_prio_src) else $error("stray priority");
    property p_unk;
        i_ce && i_unk_valid |=> o_unk_valid;
    endproperty
    a_unk: assert property (p_unk) else $error("no forward mask");
    property p_hit1;
        o_mgmt_hit_port1 |-> ($past(i_mgmt_valid) || $past(!i_ce)) && !o_mgmt_hit_port2;
    endproperty
    a_hit1: assert property (p_hit1) else $error("stray port 1 hit");
    property p_hit2;
        o_mgmt_hit_port2 |-> $past(i_mgmt_valid) || $past(!i_ce);
    endproperty
    a_hit2: assert property (p_hit2) else $error("stray port 2 hit");
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the global configuration register bank.
// Assumes one 10 MHz clock; clock enable held high except in the t_ce scenario.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: output differs", $time); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, lv = 1'b0;
    logic       i_ce = 1'b1;
    logic [6:0] i_addr = '0;
    logic [7:0] i_wdata = '0, o_rdata, got;
    logic [4:0] lval = '0;
    logic [1:0] o_prio, o_cpu_clk_sel;
    logic [2:0] o_unk_ports;
    logic       o_prio_valid, o_unk_valid, o_mgmt_hit_port1, o_mgmt_hit_port2;
    logic       o_pad_drive_high, o_phy_base_valid;
    int         miscompares = 0, samples_checked = 0;
    logic [7:0] rv [7] = '{8'h24, 8'h35, 8'h88, 8'h50, 8'hFA, 8'h47, 8'h08};
    sgc_global_regs u_sgc_global_regs (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_tag_valid(lv), .i_tag_pcp(lval[2:0]),
        .o_prio_valid(o_prio_valid), .o_prio(o_prio), .i_unk_valid(lv),
        .i_unk_default_ports(lval[2:0]), .o_unk_valid(o_unk_valid),
        .o_unk_ports(o_unk_ports), .i_mgmt_valid(lv), .i_mgmt_phy_addr(lval),
        .o_mgmt_hit_port1(o_mgmt_hit_port1), .o_mgmt_hit_port2(o_mgmt_hit_port2),
        .o_cpu_clk_sel(o_cpu_clk_sel), .o_pad_drive_high(o_pad_drive_high),
        .o_phy_base_valid(o_phy_base_valid));
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    // ------------------------------------------------------------
    // Bus and lookup tasks
    // ------------------------------------------------------------
    task automatic go;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        lv <= 1'b0;
        @(negedge i_sys_clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        go;
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        go;
        got = o_rdata;
    endtask
    // One value feeds all three lookups at once
    task automatic lk(input logic [4:0] v);
        @(posedge i_sys_clk);
        lv <= 1'b1;
        lval <= v;
        go;
    endtask
    task automatic end_of_test;
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 9; i < 16; i++) begin
            rd(7'(i));
            `CHK(got, rv[i-9])
        end
    endtask
    task automatic t_ro_clk;
        wr(7'h09, 8'hFF);
        wr(7'h0A, 8'h00);
        rd(7'h09);
        `CHK(got, 8'h24)
        rd(7'h0A);
        `CHK(got, 8'h35)
        // Ends on the slowest clock, the power-saving choice
        for (int s = 2; s >= 0; s--) begin
            wr(7'h0B, {2'(s), 6'h37});
            rd(7'h0B);
            `CHK(got, {2'(s), 6'h08})
            `CHK(o_cpu_clk_sel, 2'(s))
        end
    endtask
    task automatic t_prio;
        for (int t = 0; t < 8; t++) begin
            lk(5'(t));
            `CHK({o_prio_valid, o_prio}, {1'b1, 2'(t >> 1)})
        end
        wr(7'h0C, 8'hE4);
        wr(7'h0D, 8'h1B);
        for (int t = 0; t < 8; t++) begin
            lk(5'(t));
            `CHK(o_prio, 2'(t < 4 ? t : 7 - t))
        end
    endtask
    task automatic t_unk;
        lk(5'h02);
        `CHK({o_unk_valid, o_unk_ports}, 4'hA)
        wr(7'h0E, 8'h85);
        lk(5'h02);
        `CHK(o_unk_ports, 3'h5)
        `CHK(o_pad_drive_high, 1'b0)
        wr(7'h0E, 8'h81);
        lk(5'h06);
        `CHK(o_unk_ports, 3'h1)
    endtask
    task automatic t_phy;
        wr(7'h0F, 8'hE8);
        lk(5'h1D);
        `CHK({o_mgmt_hit_port1, o_mgmt_hit_port2}, 2'b10)
        lk(5'h1E);
        `CHK({o_mgmt_hit_port1, o_mgmt_hit_port2}, 2'b01)
        wr(7'h0F, 8'hF7);
        rd(7'h0F);
        `CHK(got, 8'hF0)
        `CHK(o_phy_base_valid, 1'b0)
        lk(5'h1E);
        `CHK({o_mgmt_hit_port1, o_mgmt_hit_port2}, 2'b00)
    endtask
    task automatic t_port;
        wr(7'h30, 8'hA5);
        wr(7'h10, 8'h5A);
        rd(7'h30);
        `CHK(got, 8'hA5)
        rd(7'h10);
        `CHK(got, 8'h5A)
        rd(7'h60);
        `CHK(got, 8'h00)
    endtask
    // Clock enable low must freeze settings and lookups
    task automatic t_ce;
        @(posedge i_sys_clk);
        i_ce <= 1'b0;
        wr(7'h0C, 8'hFF);
        lk(5'h03);
        `CHK(o_prio_valid, 1'b0)
        @(posedge i_sys_clk);
        i_ce <= 1'b1;
        rd(7'h0C);
        `CHK(got, 8'hE4)
    endtask
    // Reset in mid-run restores the defaults read back at 0x09 to 0x0F
    task automatic t_rerst;
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_reset;
    endtask
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_reset;
        t_ro_clk;
        t_prio;
        t_unk;
        t_phy;
        t_port;
        t_ce;
        t_rerst;
        end_of_test;
    end
    // Hang guard
    initial begin
        #1ms;
        miscompares++;
        end_of_test;
    end
endmodule
bind sgc_global_regs sgc_properties u_sgc_properties (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tag_valid(i_tag_valid), .o_prio_valid(o_prio_valid), .i_unk_valid(i_unk_valid),
    .o_unk_valid(o_unk_valid), .i_mgmt_valid(i_mgmt_valid),
    .o_mgmt_hit_port1(o_mgmt_hit_port1), .o_mgmt_hit_port2(o_mgmt_hit_port2),
    .o_cpu_clk_sel(o_cpu_clk_sel));
